// ===== dv/host_ctrl_model.sv
// Purpose: host controller model on the host pins of the tape port
// Assumes: host_o comes from flops on pclk
// Notes: last word is held high on reads, which the unit must ignore
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic start,
  input wire logic [2:0] cmd_sel,
  input wire logic [7:0] wr_len,
  // host pins
  input wire tape_port_pkg::host_out_t host_o,
  output tape_port_pkg::host_in_t host_i,
  // observations
  output logic [7:0] rd_cnt,
  output logic [7:0] wr_cnt,
  output logic [8:0] last_rd,
  output logic [8:0] rd_b1
);
  import tape_port_pkg::*;
  logic go_r, stb_q, dem_q;
  // go and command stand together until data busy answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) go_r <= 1'b0;
    else if (start) go_r <= 1'b1;
    else if (host_o.data_phase_busy) go_r <= 1'b0;
  end
  // last word after wr_len demands; data moves on each demand
  assign host_i = '{command_go: go_r, cmd: cmd_sel, write_data: 8'hC0 + wr_cnt,
    last_word_flag: (cmd_sel != CMD_BLOCK_WRITE) || (wr_cnt >= wr_len)};
  // sample the read bus on each strobe that has no demand with it, count demands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {stb_q, dem_q, rd_cnt, wr_cnt, last_rd, rd_b1} <= '0;
    end else begin
      stb_q <= host_o.read_char_strobe;
      dem_q <= host_o.write_char_demand;
      if (start) begin
        rd_cnt <= '0;
        wr_cnt <= '0;
      end else if (host_o.read_char_strobe && !stb_q && !host_o.write_char_demand) begin
        rd_cnt <= rd_cnt + 8'h01;
        last_rd <= {host_o.read_data_lines, host_o.read_parity_line};
        if (rd_cnt == 8'h01) rd_b1 <= {host_o.read_data_lines, host_o.read_parity_line};
      end else if (host_o.write_char_demand && !dem_q) begin
        wr_cnt <= wr_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_tape_host_transfer_port.sv
// Purpose: self-checking bench of the tape host transfer port
// Assumes: zero wait APB, ramp shortened to RC cycles per ms
// Notes: tape side is driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module tb_tape_host_transfer_port;
  import tape_port_pkg::*;
  localparam int RC = 10;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, start = 1'b0, stb_q = 1'b0, dem_q = 1'b0;
  logic [2:0] cmd = '0;
  logic [7:0] wlen = '0, rdn, wrn, last_wr = '0;
  logic [8:0] lrd, b1;
  host_in_t hi;
  host_out_t ho;
  tape_in_t ti = '0;
  tape_out_t tout;
  int mismatches = 0, checked = 0, cyc = 0, n = 0, rs_c = 0, ws_c = 0, rd_w = 0, wr_w = 0;
  int dec_n = 0, wrv_n = 0, r5_err = 0, tm_n = 0;
  // ****************************************************************
  // design, host model and clock
  // ****************************************************************
  tape_host_transfer_port #(.RAMP_CYC(RC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_i(hi), .host_o(ho), .tape_i(ti), .tape_o(tout));
  host_ctrl_model host (.pclk(pclk), .presetn(presetn), .start(start), .cmd_sel(cmd),
    .wr_len(wlen), .host_o(ho), .host_i(hi), .rd_cnt(rdn), .wr_cnt(wrn), .last_rd(lrd),
    .rd_b1(b1));
  always #50 pclk = ~pclk;
  // strobe widths, pulse counts and timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    stb_q <= ho.read_char_strobe;
    dem_q <= ho.write_char_demand;
    rs_c <= ho.read_char_strobe ? rs_c + 1 : 0;
    ws_c <= ho.write_char_demand ? ws_c + 1 : 0;
    if (stb_q && !ho.read_char_strobe) rd_w <= rs_c;
    if (dem_q && !ho.write_char_demand) wr_w <= ws_c;
    if (ho.write_char_demand && !dem_q && ho.read_char_strobe !== 1'b1) r5_err <= r5_err + 1;
    if (tout.decel) dec_n <= dec_n + 1;
    if (ho.tape_mark_seen) tm_n <= tm_n + 1;
    if (tout.wr_valid) begin
      wrv_n <= wrv_n + 1;
      last_wr <= tout.wr_data;
    end
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [2:0] c, input logic [7:0] wl);
    @(posedge pclk);
    cmd <= c;
    wlen <= wl;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    while (ho.unit_busy_ack !== 1'b1) @(posedge pclk);
    n = 0;
    while (ho.data_phase_busy !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    chk("ubusy at dbusy", ho.unit_busy_ack, 1);
  endtask
  task automatic finish_cmd;
    while (ho.data_phase_busy !== 1'b0) @(posedge pclk);
    chk("ubusy after data", ho.unit_busy_ack, 1);
    n = dec_n;
    while (ho.unit_busy_ack !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("decel pulse", dec_n - n, 1);
  endtask
  // one offered character, then room for the pacing period
  task automatic chr(input logic [7:0] d, input logic nd);
    @(posedge pclk);
    ti.valid <= 1'b1;
    ti.nondata <= nd;
    ti.data <= d;
    @(posedge pclk);
    ti.valid <= 1'b0;
    repeat (15) @(posedge pclk);
  endtask
  task automatic ev(input logic [15:0] m);
    @(posedge pclk);
    ti <= ti | m;
    @(posedge pclk);
    ti <= ti & ~m;
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("idle parity", ho.read_parity_line, 1);
    apb(0, CTRL_OFS, 0);
    chk("ctrl reset", q, CTRL_RST);
    apb(0, 12'h0FC, 0);
    chk("unmapped", e, 1);
    go(CMD_FWD_READ, 0);
    chk("ramp 00", n <= 1, 1);
    chr(8'hA5, 0);
    chr(8'h3C, 1);
    chr(8'h07, 0);
    chk("read chars", rdn, 2);
    chk("last char", lrd, 9'h00E);
    chk("read strobe width", rd_w, RD_STROBE_CYC);
    ev(16'h0020);
    finish_cmd();
    go(CMD_FWD_READ, 0);
    ev(16'h0010);
    finish_cmd();
    chk("mark flag", tm_n > 0, 1);
    chk("mark strobes", rdn, 0);
    apb(1, CTRL_OFS, 32'h0000_0009);
    apb(0, CTRL_OFS, 0);
    chk("ctrl readback", q, 32'h0000_0009);
    go(CMD_BLOCK_WRITE, 3);
    chk("ramp 01", (n >= RC - 1) && (n <= RC + 2), 1);
    while (wrn < 3) @(posedge pclk);
    repeat (30) @(posedge pclk);
    chk("demands", wrn, 3);
    chk("written", wrv_n, 3);
    chk("last written", last_wr, 8'hC3);
    chk("demand width", wr_w, CYCLE_NS[1] / CLK_NS - WR_SHORT_CYC);
    chk("strobe with demand", r5_err, 0);
    chk("dbusy until check", ho.data_phase_busy, 1);
    ev(16'h0002);
    finish_cmd();
    go(CMD_REV_READ, 0);
    chk("reverse motion", {tout.rev, tout.fwd}, 2'b10);
    chr(8'h81, 0);
    chk("reverse chars", rdn, 1);
    ev(16'h0020);
    finish_cmd();
    go(CMD_SENSE, 0);
    finish_cmd();
    chk("sense bytes", rdn, SENSE_BYTES);
    chk("sense byte1", b1, 9'h051);
    apb(1, CTRL_OFS, 32'h0000_0020);
    go(CMD_FWD_READ, 0);
    ev(16'h0020);
    while (ho.data_phase_busy !== 1'b0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk("prefetch", tout.prefetch, 1);
    ev(16'h0004);
    repeat (3) @(posedge pclk);
    chk("eot stops prefetch", tout.prefetch, 0);
    repeat (HOLD_CYC + 10) @(posedge pclk);
    chk("cached ubusy", ho.unit_busy_ack, 1);
    test_done();
  end
endmodule
`default_nettype wire

// ===== hw/tape_host_transfer_port.sv
// Purpose: host transfer port of a tape unit: command handshake, read and write strobes
// Assumes: host pins are asynchronous; tape datapath runs on pclk
// Notes: registers over APB, zero wait states, unmapped addresses answer pslverr
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] eight rates set cycle; read strobe 400 ns
// [RULE2] write strobe is cycle minus 600 ns
// [RULE3] ramp field sets go to data busy delay
// [RULE4] one read strobe per character sent
// [RULE5] read strobe accompanies each write demand
// [RULE6] nine read lines, bit 0 msb, parity
// [RULE7] last word ignored during reads
// [RULE8] check all characters, send only data
// [RULE9] go, unit busy, motion, data busy, strobes
// [RULE10] data busy drops after data and status
// [RULE11] no new command: decelerate, drop unit busy
// [RULE12] cached read ahead retries 0/5/10/15
// [RULE13] failed prefetched block flags data check
// [RULE14] end of tape stops read ahead
// [RULE15] direct tape reads report errors unretried
// [RULE16] cached mode may hold unit busy
// [RULE17] tape mark: skip, flag, no strobes; only uncached forward reads act on it
// [RULE18] reverse read backward, never read ahead
// [RULE19] write, read back check, then end
// [RULE20] demand until host raises last word
// [RULE21] cached write error: backspace, erase, rewrite
// [RULE22] final write failure: flag, reject until sense
// [RULE23] one demand pulse per written character
module tape_host_transfer_port #(
  parameter int RAMP_CYC = tape_port_pkg::RAMP_CYC_PER_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tape_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire tape_port_pkg::host_in_t host_i,
  output tape_port_pkg::host_out_t host_o,
  // tape datapath
  input wire tape_port_pkg::tape_in_t tape_i,
  output tape_port_pkg::tape_out_t tape_o
);
  import tape_port_pkg::*;

  typedef enum {ST_IDLE, ST_RAMP, ST_READ, ST_WRITE, ST_CHECK, ST_SENSE, ST_END,
                ST_HOLD} state_t;

  localparam int HIN_W = $bits(host_in_t);

  state_t state_r;
  logic [HIN_W-1:0] s1_r, s2_r, s3_r, stab_r;
  host_in_t hq;
  logic go_prev_r, go_rise;
  logic [CTRL_W-1:0] ctrl_r;
  logic [2:0] rate;
  logic [1:0] ramp_sel, rrty_sel, wrty_sel;
  logic cached;
  logic [7:0] cyc_len, wr_wid, rd_lim, wr_lim;
  logic [31:0] ramp_len, ramp_cnt_r;
  logic [7:0] hold_cnt_r, pace_cnt_r, rs_cnt_r, wd_cnt_r, ra_try_r, wr_try_r;
  logic pace_busy, pace_end_r, blk_end_r;
  logic ubusy_r, dbusy_r, tm_r, hf_r, dchk_r, hf_pend_r, ra_fail_r, host_ra_r;
  logic eot_r, fwd_r, rev_r, decel_r, bksp_r, erase_r, pref_r;
  logic rstrobe_r, demand_r, rd_ready_r, wr_valid_r, par_r;
  logic [7:0] rdata_r, wdata_r;
  logic [3:0] sense_idx_r;
  logic [31:0] char_cnt_r;
  logic [7:0] sense_byte;
  logic accept;

  // ****************************************************************
  // host pin synchronisers
  // ****************************************************************
  // three stages; a bit changes once the second and third agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stab_r <= '0;
      go_prev_r <= 1'b0;
    end else begin
      s1_r <= host_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= (s2_r & s3_r) | (stab_r & (s2_r ^ s3_r));
      go_prev_r <= hq.command_go;
    end
  end

  assign hq = host_in_t'(stab_r);
  assign go_rise = hq.command_go & ~go_prev_r;

  // ****************************************************************
  // switch settings and derived timing
  // ****************************************************************
  assign rate = ctrl_r[CTRL_RATE_LSB +: 3];
  assign ramp_sel = ctrl_r[CTRL_RAMP_LSB +: 2];
  assign cached = ctrl_r[CTRL_CACHE_BIT];
  assign rrty_sel = ctrl_r[CTRL_RRTY_LSB +: 2];
  assign wrty_sel = ctrl_r[CTRL_WRTY_LSB +: 2];
  assign cyc_len = 8'(CYCLE_NS[rate] / CLK_NS); // [RULE1]
  assign wr_wid = 8'(CYCLE_NS[rate] / CLK_NS - WR_SHORT_CYC); // [RULE2]
  assign ramp_len = (RAMP_MIN_MS[ramp_sel] == 0) ? 32'h0000_0001 :
                    32'(RAMP_MIN_MS[ramp_sel] * RAMP_CYC); // [RULE3]
  assign rd_lim = 8'(int'(rrty_sel) * RETRY_STEP); // [RULE12]
  assign wr_lim = (wrty_sel == 2'h3) ? 8'(3 * RETRY_STEP) :
                  8'((int'(wrty_sel) + 1) * RETRY_STEP); // [RULE21]
  assign pace_busy = (pace_cnt_r != 8'h00);
  assign accept = tape_i.valid & rd_ready_r;

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  // handshake lines, motion and per-command status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      ubusy_r <= 1'b0;
      dbusy_r <= 1'b0;
      tm_r <= 1'b0;
      hf_r <= 1'b0;
      dchk_r <= 1'b0;
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      decel_r <= 1'b0;
      ramp_cnt_r <= 32'h0000_0000;
      hold_cnt_r <= 8'h00;
      blk_end_r <= 1'b0;
      host_ra_r <= 1'b0;
    end else begin
      decel_r <= 1'b0;
      case (state_r)
        ST_IDLE, ST_HOLD: begin
          if (go_rise) begin
            ubusy_r <= 1'b1; // [RULE9]
            blk_end_r <= 1'b0;
            host_ra_r <= cached & ra_fail_r & (hq.cmd == CMD_FWD_READ);
            if (hf_pend_r && hq.cmd != CMD_SENSE) begin
              hf_r <= 1'b1; // [RULE22]
              state_r <= ST_END;
            end else if (hq.cmd == CMD_SENSE) begin
              state_r <= ST_SENSE;
            end else if (hq.cmd == CMD_FWD_READ || hq.cmd == CMD_REV_READ ||
                         hq.cmd == CMD_BLOCK_WRITE) begin
              ramp_cnt_r <= ramp_len; // [RULE3]
              fwd_r <= (hq.cmd != CMD_REV_READ);
              rev_r <= (hq.cmd == CMD_REV_READ); // [RULE18]
              state_r <= ST_RAMP;
            end else begin
              state_r <= ST_END;
            end
          end else if (state_r == ST_HOLD) begin
            if (hold_cnt_r != 8'h00) begin
              hold_cnt_r <= hold_cnt_r - 8'h01;
            end else begin
              decel_r <= 1'b1; // [RULE11]
              fwd_r <= 1'b0;
              rev_r <= 1'b0;
              ubusy_r <= cached; // [RULE16]
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RAMP: begin
          if (ramp_cnt_r > 32'h0000_0001) begin
            ramp_cnt_r <= ramp_cnt_r - 32'h0000_0001;
          end else begin
            dbusy_r <= 1'b1; // [RULE9]
            state_r <= (rev_r || hq.cmd != CMD_BLOCK_WRITE) ? ST_READ : ST_WRITE;
          end
        end
        ST_READ: begin
          // last word is not looked at here
          if (tape_i.tape_mark && !cached && fwd_r) begin
            tm_r <= 1'b1; // [RULE17]
            state_r <= ST_END;
          end else begin
            if (tape_i.uncorr) begin
              dchk_r <= 1'b1; // [RULE15]
            end
            if (tape_i.block_end) begin
              blk_end_r <= 1'b1;
            end
            if (blk_end_r && !pace_busy && !rstrobe_r) begin
              if (host_ra_r) begin
                dchk_r <= 1'b1; // [RULE13]
              end
              state_r <= ST_END; // [RULE7]
            end
          end
        end
        ST_WRITE: begin
          if (pace_end_r && hq.last_word_flag) begin
            state_r <= ST_CHECK; // [RULE20]
          end
        end
        ST_CHECK: begin
          if (tape_i.wr_done && !(tape_i.wr_fail && cached && wr_try_r < wr_lim)) begin
            dchk_r <= tape_i.wr_fail & ~cached;
            state_r <= ST_END; // [RULE19]
          end
        end
        ST_SENSE: begin
          dbusy_r <= 1'b1; // [RULE9]
          if (sense_idx_r == 4'(SENSE_BYTES) && !pace_busy) begin
            state_r <= ST_END;
          end
        end
        ST_END: begin
          // status lines settle one cycle before data busy falls
          dbusy_r <= 1'b0; // [RULE10]
          hold_cnt_r <= 8'(HOLD_CYC);
          state_r <= ST_HOLD;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (state_r inside {ST_IDLE, ST_HOLD} && go_rise) begin
        tm_r <= 1'b0;
        hf_r <= hf_pend_r & (hq.cmd != CMD_SENSE);
        dchk_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read-ahead and write recovery
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eot_r <= 1'b0;
      pref_r <= 1'b0;
      ra_try_r <= 8'h00;
      ra_fail_r <= 1'b0;
      wr_try_r <= 8'h00;
      hf_pend_r <= 1'b0;
      bksp_r <= 1'b0;
      erase_r <= 1'b0;
    end else begin
      bksp_r <= 1'b0;
      erase_r <= 1'b0;
      if (tape_i.eot && !rev_r) begin
        eot_r <= 1'b1; // [RULE14]
      end else if (rev_r) begin
        eot_r <= 1'b0;
      end
      pref_r <= cached & ~eot_r & fwd_r & ~rev_r &
                (state_r == ST_IDLE || state_r == ST_HOLD); // [RULE14] [RULE18]
      if (pref_r && tape_i.uncorr) begin
        if (ra_try_r < rd_lim) begin
          bksp_r <= 1'b1; // [RULE12]
          ra_try_r <= ra_try_r + 8'h01;
        end else begin
          ra_fail_r <= 1'b1;
          ra_try_r <= 8'h00;
        end
      end else if (pref_r && tape_i.block_end) begin
        ra_try_r <= 8'h00;
      end
      if (state_r == ST_READ && blk_end_r && host_ra_r) begin
        ra_fail_r <= 1'b0;
      end
      if (state_r == ST_CHECK && tape_i.wr_done && tape_i.wr_fail && cached) begin
        if (wr_try_r < wr_lim) begin
          bksp_r <= 1'b1; // [RULE21]
          erase_r <= 1'b1;
          wr_try_r <= wr_try_r + 8'h01;
        end else begin
          hf_pend_r <= 1'b1; // [RULE22]
          wr_try_r <= 8'h00;
        end
      end else if (state_r == ST_END) begin
        wr_try_r <= 8'h00;
      end
      if (state_r == ST_SENSE && sense_idx_r == 4'(SENSE_BYTES)) begin
        hf_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // character pacer
  // ****************************************************************
  // sense bytes: status first, switch settings second, rest zero
  always_comb begin
    sense_byte = 8'h00;
    if (sense_idx_r == 4'h0) begin
      sense_byte = {dchk_r, hf_pend_r, tm_r, eot_r, ra_fail_r, cached, 2'h0};
    end else if (sense_idx_r == 4'h1) begin
      sense_byte = {rate, ramp_sel, 1'b0, wrty_sel};
    end
  end

  // strobes, read bus and write capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_cnt_r <= 8'h00;
      rs_cnt_r <= 8'h00;
      wd_cnt_r <= 8'h00;
      pace_end_r <= 1'b0;
      rstrobe_r <= 1'b0;
      demand_r <= 1'b0;
      rdata_r <= 8'h00;
      par_r <= 1'b1;
      rd_ready_r <= 1'b0;
      wr_valid_r <= 1'b0;
      wdata_r <= 8'h00;
      sense_idx_r <= 4'h0;
      char_cnt_r <= 32'h0000_0000;
    end else begin
      wr_valid_r <= 1'b0;
      pace_end_r <= (pace_cnt_r == 8'h01);
      if (pace_busy) begin
        pace_cnt_r <= pace_cnt_r - 8'h01;
      end
      if (rs_cnt_r > 8'h01) begin
        rs_cnt_r <= rs_cnt_r - 8'h01;
      end else begin
        rs_cnt_r <= 8'h00;
        rstrobe_r <= 1'b0;
      end
      if (wd_cnt_r > 8'h01) begin
        wd_cnt_r <= wd_cnt_r - 8'h01;
      end else if (wd_cnt_r == 8'h01) begin
        wd_cnt_r <= 8'h00;
        demand_r <= 1'b0;
        wr_valid_r <= 1'b1; // host data taken at the trailing edge
        wdata_r <= hq.write_data;
      end
      rd_ready_r <= (state_r == ST_READ) & ~pace_busy & ~rstrobe_r & ~accept;
      if (state_r == ST_IDLE || state_r == ST_HOLD) begin
        sense_idx_r <= 4'h0;
        if (go_rise) begin
          char_cnt_r <= 32'h0000_0000;
        end
      end
      if (accept && !tape_i.nondata) begin
        rdata_r <= tape_i.data; // [RULE8]
        par_r <= ~^tape_i.data;
        rstrobe_r <= 1'b1; // [RULE4]
        rs_cnt_r <= 8'(RD_STROBE_CYC);
        pace_cnt_r <= cyc_len;
        char_cnt_r <= char_cnt_r + 32'h0000_0001;
      end else if (state_r == ST_WRITE && !pace_busy && !(pace_end_r && hq.last_word_flag)) begin
        demand_r <= 1'b1; // [RULE23]
        rstrobe_r <= 1'b1; // [RULE5]
        wd_cnt_r <= wr_wid; // [RULE2]
        rs_cnt_r <= 8'(RD_STROBE_CYC); // [RULE1]
        pace_cnt_r <= cyc_len - 8'h01;
        char_cnt_r <= char_cnt_r + 32'h0000_0001;
      end else if (state_r == ST_SENSE && dbusy_r && !pace_busy && !rstrobe_r &&
                   sense_idx_r != 4'(SENSE_BYTES)) begin
        rdata_r <= sense_byte; // [RULE6]
        par_r <= ~^sense_byte;
        rstrobe_r <= 1'b1;
        rs_cnt_r <= 8'(RD_STROBE_CYC);
        pace_cnt_r <= cyc_len;
        sense_idx_r <= sense_idx_r + 4'h1;
      end
    end
  end

  // ****************************************************************
  // apb registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          CTRL_OFS: begin
            prdata <= 32'(ctrl_r);
          end
          STAT_OFS: begin
            prdata <= {22'h0, hf_pend_r, ra_fail_r, eot_r, dchk_r, tm_r,
                       ubusy_r, dbusy_r, 3'(state_r)};
          end
          CNT_OFS: begin
            prdata <= char_cnt_r;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
        ctrl_r <= pwdata[CTRL_W-1:0]; // takes effect with the access edge
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign host_o = '{read_char_strobe: rstrobe_r, write_char_demand: demand_r,
                    read_data_lines: rdata_r, read_parity_line: par_r,
                    unit_busy_ack: ubusy_r, data_phase_busy: dbusy_r,
                    tape_mark_seen: tm_r, hard_fail_flag: hf_r, data_check: dchk_r};
  assign tape_o = '{fwd: fwd_r, rev: rev_r, decel: decel_r, backspace: bksp_r,
                    erase: erase_r, prefetch: pref_r, rd_ready: rd_ready_r,
                    wr_valid: wr_valid_r, wr_data: wdata_r};

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_RD_WIDTH: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    $rose(rstrobe_r) |-> rstrobe_r [*4] ##1 !rstrobe_r)
    else $error("read strobe width is not four cycles");
  AST_WR_WIDTH: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    $rose(demand_r) && rate == 3'h1 |-> demand_r [*6] ##1 !demand_r)
    else $error("write demand width wrong at rate one");
  AST_DEMAND_PAIRS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    $rose(demand_r) |-> $rose(rstrobe_r))
    else $error("write demand without read strobe");
  AST_STROBE_IN_DATA: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    rstrobe_r |-> dbusy_r && ubusy_r)
    else $error("strobe outside data phase");
  AST_DBUSY_ORDER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    $rose(dbusy_r) |-> $past(ubusy_r))
    else $error("data busy rose before unit busy");
  AST_PARITY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    $rose(rstrobe_r) |-> host_o.read_parity_line == ~^host_o.read_data_lines)
    else $error("read parity is not odd");
  AST_MARK_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    $rose(tm_r) |-> !rstrobe_r ##1 !dbusy_r)
    else $error("tape mark block strobed data");
  AST_UBUSY_DROP: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    $fell(ubusy_r) |-> !dbusy_r && decel_r && !cached)
    else $error("unit busy dropped out of order");
  AST_REJECT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
    state_r == ST_IDLE && go_rise && hf_pend_r && hq.cmd != CMD_SENSE
    |=> hf_r && !dbusy_r ##1 !dbusy_r)
    else $error("command not rejected after hard failure");
  AST_NO_PREFETCH: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    pref_r |-> !eot_r || !$past(eot_r))
    else $error("read ahead past end of tape");

endmodule

`default_nettype wire

// ===== pkg/tape_port_pkg.sv
// Purpose: shared constants, field layouts and carriers of the tape host transfer port
// Assumes: one 10 MHz clock; APB register access with 32-bit data
// Notes: timing figures are kept in their own unit, cycle counts derive from them
package tape_port_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_NS = 100;
  localparam int RD_STROBE_NS = 400;
  localparam int WR_SHORT_NS = 600;
  localparam int RD_STROBE_CYC = (RD_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_SHORT_CYC = WR_SHORT_NS / CLK_NS;
  localparam int CYCLE_NS [8] = '{1000, 1200, 1400, 1600, 2000, 3200, 5000, 13200};
  localparam int RAMP_MIN_MS [4] = '{0, 1, 8, 12};
  localparam int MS_NS = 1000000;
  localparam int RAMP_CYC_PER_MS = MS_NS / CLK_NS;
  localparam int HOLD_NS = 2000;
  localparam int HOLD_CYC = HOLD_NS / CLK_NS;
  localparam int RETRY_STEP = 5;
  localparam int SENSE_BYTES = 8;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] CNT_OFS = 12'h008;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_RAMP_LSB = 3;
  localparam int CTRL_CACHE_BIT = 5;
  localparam int CTRL_RRTY_LSB = 6;
  localparam int CTRL_WRTY_LSB = 8;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // ****************************************************************
  // command codes on the host command lines
  // ****************************************************************
  localparam logic [2:0] CMD_FWD_READ = 3'h1;
  localparam logic [2:0] CMD_REV_READ = 3'h2;
  localparam logic [2:0] CMD_BLOCK_WRITE = 3'h3;
  localparam logic [2:0] CMD_SENSE = 3'h4;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic command_go;
    logic last_word_flag;
    logic [2:0] cmd;
    logic [7:0] write_data;
  } host_in_t;

  typedef struct packed {
    logic read_char_strobe;
    logic write_char_demand;
    logic [7:0] read_data_lines;
    logic read_parity_line;
    logic unit_busy_ack;
    logic data_phase_busy;
    logic tape_mark_seen;
    logic hard_fail_flag;
    logic data_check;
  } host_out_t;

  typedef struct packed {
    logic valid;
    logic nondata;
    logic [7:0] data;
    logic block_end;
    logic tape_mark;
    logic uncorr;
    logic eot;
    logic wr_done;
    logic wr_fail;
  } tape_in_t;

  typedef struct packed {
    logic fwd;
    logic rev;
    logic decel;
    logic backspace;
    logic erase;
    logic prefetch;
    logic rd_ready;
    logic wr_valid;
    logic [7:0] wr_data;
  } tape_out_t;

endpackage
